// >>> sia_pkg.sv
// Purpose : shared constants of the status interrupt aggregator
// Assumes : 24-bit status and mask words, 8-bit command byte on the serial port
// Notes   : bit positions run from the most significant end of the status word
package sia_pkg;
  localparam int WORD_W = 24;
  localparam int CMD_W  = 8;
  localparam int CNT_W  = 6;
  localparam int PINS   = 4;

  // ----------
  // status and mask bit positions
  // ----------
  localparam int BIT_SUPPLY_A      = 23;
  localparam int BIT_SUPPLY_B      = 22;
  localparam int BIT_ANALOG_SUPPLY = 21;
  localparam int BIT_DONE          = 20;
  localparam int BIT_BUF_FULL      = 19;
  localparam int BIT_ACC_FULL      = 18;
  localparam int BIT_UPPER         = 17;
  localparam int BIT_LOWER         = 16;
  localparam int LSB_ANALOG_RISE   = 12;
  localparam int LSB_ANALOG_FALL   = 8;
  localparam int LSB_DIGITAL_RISE  = 4;
  localparam int LSB_DIGITAL_FALL  = 0;

  // ----------
  // reset values
  // ----------
  localparam logic [23:0] STATUS_DEFAULT  = 24'h000000;
  localparam logic [23:0] STATUS_POWER_UP = 24'hC00000;
  localparam logic [23:0] MASK_DEFAULT    = 24'hFFFFFF;

  // ----------
  // command bytes: bit 7 high reads, low writes
  // ----------
  localparam logic [7:0] CMD_RD_STATUS = 8'h90;
  localparam logic [7:0] CMD_RD_MASK   = 8'h91;
  localparam logic [7:0] CMD_WR_MASK   = 8'h11;
  localparam logic [7:0] CMD_WR_RESET  = 8'h12;

  // ----------
  // serial clock edge counts within a frame
  // ----------
  localparam logic [5:0] EDGE_CMD   = 6'h08;
  localparam logic [5:0] EDGE_RESET = 6'h10;
  localparam logic [5:0] EDGE_WORD  = 6'h20;

  // pin function select: bit 0 routes the interrupt to pin one, bit 1 to pin two
  localparam int SEL_PIN_ONE = 0;
  localparam int SEL_PIN_TWO = 1;
endpackage : sia_pkg

// >>> sia_serial_port.sv
// Purpose : 4-wire serial port slave, oversampled by the system clock
// Assumes : mode 0 framing, sclk far slower than clock, cs_n active low
// Notes   : emits one-cycle pulses at the 8th, 16th and 32nd rising sclk edge
`timescale 1ns/1ns
module sia_serial_port
  import sia_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic                  din,
  input  wire logic                  tx_load,
  input  wire logic [sia_pkg::WORD_W-1:0] tx_word,
  output logic                       dout,
  output logic                       dout_oe,
  output logic [sia_pkg::CMD_W-1:0]  cmd_byte,
  output logic [sia_pkg::WORD_W-1:0] rx_word,
  output logic                       cmd_pulse,
  output logic                       edge16_pulse,
  output logic                       word_pulse,
  output logic                       frame_end
);
  import sia_pkg::*;

  logic [2:0]        sclk_sync_reg;
  logic [2:0]        cs_sync_reg;
  logic [1:0]        din_sync_reg;
  logic [CNT_W-1:0]  count_reg;
  logic [31:0]       shift_reg;
  logic [WORD_W-1:0] tx_reg;
  logic [CMD_W-1:0]  cmd_reg;
  logic              pulse8_reg;
  logic              pulse16_reg;
  logic              pulse32_reg;
  logic              end_reg;

  // ---------------------------------------------------------------
  // edge decode on the second and third stages only
  // ---------------------------------------------------------------
  wire              sel_n     = cs_sync_reg[1];
  wire              rise      = sclk_sync_reg[1] & ~sclk_sync_reg[2] & ~sel_n;
  wire              fall      = ~sclk_sync_reg[1] & sclk_sync_reg[2] & ~sel_n;
  wire              cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire [CNT_W-1:0]  count_inc = count_reg + 6'h01;
  // no shift before the first data bit has been sampled by the host
  wire              tx_shift  = fall & (count_reg > EDGE_CMD);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      din_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n};
      din_sync_reg  <= {din_sync_reg[0], din};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || sel_n) begin
      count_reg <= 6'h00;
    end else if (rise && count_reg != 6'h3F) begin
      count_reg <= count_inc;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_reg <= 32'h0;
    end else if (rise) begin
      shift_reg <= {shift_reg[30:0], din_sync_reg[1]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_reg <= 8'h00;
    end else if (rise && count_inc == EDGE_CMD) begin
      cmd_reg <= {shift_reg[6:0], din_sync_reg[1]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pulse8_reg  <= 1'b0;
      pulse16_reg <= 1'b0;
      pulse32_reg <= 1'b0;
      end_reg     <= 1'b0;
    end else begin
      pulse8_reg  <= rise & (count_inc == EDGE_CMD);
      pulse16_reg <= rise & (count_inc == EDGE_RESET);
      pulse32_reg <= rise & (count_inc == EDGE_WORD);
      end_reg     <= cs_rise;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_reg <= 24'h000000;
    end else if (tx_load) begin
      tx_reg <= tx_word;
    end else if (tx_shift) begin
      tx_reg <= {tx_reg[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= ~sel_n;
    end
  end

  assign dout         = tx_reg[WORD_W-1];
  assign cmd_byte     = cmd_reg;
  assign rx_word      = shift_reg[WORD_W-1:0];
  assign cmd_pulse    = pulse8_reg;
  assign edge16_pulse = pulse16_reg;
  assign word_pulse   = pulse32_reg;
  assign frame_end    = end_reg;
endmodule : sia_serial_port

// >>> sia_status_aggregator.sv
// Purpose : sticky event status word, mask and interrupt pins behind the serial port
// Assumes : event pulses come from logic on clock; pins and comparators are asynchronous
// Notes   : hardware reset sets both digital supply flags, software reset does not
// Function
// - 24-bit status; unmasked set flag raises interrupt
// - set flags and asserted interrupt stay set
// - completed status read clears all flags except supply flags still low
// - flags set during status read applied afterwards; clears take effect at once
// - supply flags clear on soft reset, else only when no longer low or monitor off
// - powered-down monitor cannot set its flag
// - digital supply flags asserted at power-up
// - done flag set on result, cleared on reads
// - buffer full at index; cleared on buffer access
// - accumulator full flag; cleared on accumulator access
// - alarm flags cleared by own threshold write
// - analog pin rise and fall flags
// - digital pin rise and fall flags
// - fixed status and mask bit order
// - mask one blocks; all masked after reset
// - interrupt drives pins selected as interrupt
// - interrupt released when status read recognised
// - interrupt reasserts after aborted read or new flag
// - software reset write at 16th sclk edge
`timescale 1ns/1ns
module sia_status_aggregator
  import sia_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    din,
  output logic                         dout,
  output logic                         dout_oe,
  input  wire logic                    supply_a_low,
  input  wire logic                    supply_b_low,
  input  wire logic                    analog_supply_low,
  input  wire logic                    supply_a_on,
  input  wire logic                    supply_b_on,
  input  wire logic                    analog_supply_on,
  input  wire logic                    conv_done_evt,
  input  wire logic                    result_read,
  input  wire logic                    buffer_write_evt,
  input  wire logic [3:0]              buffer_write_addr,
  input  wire logic [3:0]              buffer_full_index,
  input  wire logic                    buffer_access,
  input  wire logic                    accum_full_evt,
  input  wire logic                    accum_access,
  input  wire logic                    upper_alarm_evt,
  input  wire logic                    lower_alarm_evt,
  input  wire logic                    upper_threshold_write,
  input  wire logic                    lower_threshold_write,
  input  wire logic [sia_pkg::PINS-1:0] analog_programmable_pin,
  input  wire logic [sia_pkg::PINS-1:0] digital_programmable_pin,
  input  wire logic [1:0]              pin_function_select,
  output logic                         reset_irq_pin_one,
  output logic                         reset_irq_pin_two,
  output logic [sia_pkg::WORD_W-1:0]   event_status,
  output logic [sia_pkg::WORD_W-1:0]   event_mask,
  output logic                         soft_reset_pulse
);
  import sia_pkg::*;

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  logic [CMD_W-1:0]  cmd_byte;
  logic [WORD_W-1:0] rx_word;
  logic              cmd_pulse;
  logic              edge16_pulse;
  logic              word_pulse;
  logic              frame_end;
  logic [WORD_W-1:0] status_reg;
  logic [WORD_W-1:0] status_next;
  logic [WORD_W-1:0] mask_reg;
  logic [WORD_W-1:0] pending_reg;
  logic              rd_active_reg;
  logic              rd_done_reg;
  logic              irq_one_reg;
  logic              irq_two_reg;
  logic              soft_reset_reg;

  wire rd_status_cmd = cmd_pulse & (cmd_byte == CMD_RD_STATUS);
  wire rd_mask_cmd   = cmd_pulse & (cmd_byte == CMD_RD_MASK);
  wire tx_load       = rd_status_cmd | rd_mask_cmd;
  wire [WORD_W-1:0] tx_word = rd_status_cmd ? status_reg : mask_reg;

  sia_serial_port u_port (
    .clock        (clock),
    .rst_n        (rst_n),
    .sclk         (sclk),
    .cs_n         (cs_n),
    .din          (din),
    .tx_load      (tx_load),
    .tx_word      (tx_word),
    .dout         (dout),
    .dout_oe      (dout_oe),
    .cmd_byte     (cmd_byte),
    .rx_word      (rx_word),
    .cmd_pulse    (cmd_pulse),
    .edge16_pulse (edge16_pulse),
    .word_pulse   (word_pulse),
    .frame_end    (frame_end)
  );

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [2:0]        supply_s1_reg;
  logic [2:0]        supply_s2_reg;
  logic [PINS-1:0]   apin_s1_reg;
  logic [PINS-1:0]   apin_s2_reg;
  logic [PINS-1:0]   apin_s3_reg;
  logic [PINS-1:0]   dpin_s1_reg;
  logic [PINS-1:0]   dpin_s2_reg;
  logic [PINS-1:0]   dpin_s3_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supply_s1_reg <= 3'h0;
      supply_s2_reg <= 3'h0;
    end else begin
      supply_s1_reg <= {supply_a_low, supply_b_low, analog_supply_low};
      supply_s2_reg <= supply_s1_reg;
    end
  end

  // third stage holds the previous level so each edge is seen once
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      apin_s1_reg <= 4'h0;
      apin_s2_reg <= 4'h0;
      apin_s3_reg <= 4'h0;
      dpin_s1_reg <= 4'h0;
      dpin_s2_reg <= 4'h0;
      dpin_s3_reg <= 4'h0;
    end else begin
      apin_s1_reg <= analog_programmable_pin;
      apin_s2_reg <= apin_s1_reg;
      apin_s3_reg <= apin_s2_reg;
      dpin_s1_reg <= digital_programmable_pin;
      dpin_s2_reg <= dpin_s1_reg;
      dpin_s3_reg <= dpin_s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // event and clear vectors
  // ---------------------------------------------------------------
  wire [2:0] monitor_on = {supply_a_on, supply_b_on, analog_supply_on};
  // a powered-down monitor cannot raise its flag
  wire [2:0] supply_set = supply_s2_reg & monitor_on;
  wire       buf_full_hit = buffer_write_evt & (buffer_write_addr == buffer_full_index);

  wire [PINS-1:0] apin_rise = apin_s2_reg & ~apin_s3_reg;
  wire [PINS-1:0] apin_fall = ~apin_s2_reg & apin_s3_reg;
  wire [PINS-1:0] dpin_rise = dpin_s2_reg & ~dpin_s3_reg;
  wire [PINS-1:0] dpin_fall = ~dpin_s2_reg & dpin_s3_reg;

  // msb-first order: supplies, done, full, accum, alarms, then pins
  wire [WORD_W-1:0] events = {supply_set, conv_done_evt, buf_full_hit, accum_full_evt,
                              upper_alarm_evt, lower_alarm_evt,
                              apin_rise, apin_fall, dpin_rise, dpin_fall};

  logic [WORD_W-1:0] side_clear;
  always_comb begin
    side_clear = 24'h000000;
    side_clear[BIT_DONE]     = result_read;
    side_clear[BIT_BUF_FULL] = buffer_access;
    side_clear[BIT_ACC_FULL] = accum_access;
    side_clear[BIT_UPPER]    = upper_threshold_write;
    side_clear[BIT_LOWER]    = lower_threshold_write;
  end

  // supply flags survive a read while their comparator still reports low
  logic [WORD_W-1:0] read_keep;
  always_comb begin
    read_keep = 24'h000000;
    read_keep[BIT_SUPPLY_A]      = supply_set[2];
    read_keep[BIT_SUPPLY_B]      = supply_set[1];
    read_keep[BIT_ANALOG_SUPPLY] = supply_set[0];
  end

  // ---------------------------------------------------------------
  // status read sequencing
  // ---------------------------------------------------------------
  wire read_ends = rd_active_reg & frame_end;
  wire soft_rst  = edge16_pulse & (cmd_byte == CMD_WR_RESET);

  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst || frame_end) begin
      rd_active_reg <= 1'b0;
    end else if (rd_status_cmd) begin
      rd_active_reg <= 1'b1;
    end
  end

  // full word shifted out before the frame closed counts as successful
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst || frame_end) begin
      rd_done_reg <= 1'b0;
    end else if (rd_active_reg && word_pulse) begin
      rd_done_reg <= 1'b1;
    end
  end

  // events seen mid-read wait here so the word being shifted stays coherent
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst || !(rd_active_reg || rd_status_cmd) || frame_end) begin
      pending_reg <= 24'h000000;
    end else begin
      pending_reg <= pending_reg | events;
    end
  end

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  wire [WORD_W-1:0] base_after_read = rd_done_reg ? (status_reg & read_keep) : status_reg;

  always_comb begin
    if (soft_rst) begin
      status_next = STATUS_DEFAULT;
    end else if (read_ends) begin
      // set wins: held and same-cycle events land after the clear
      status_next = (base_after_read & ~side_clear) | pending_reg | events;
    end else if (rd_active_reg || rd_status_cmd) begin
      status_next = status_reg & ~side_clear;
    end else begin
      status_next = (status_reg & ~side_clear) | events;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_reg <= STATUS_POWER_UP;
    end else begin
      status_reg <= status_next;
    end
  end

  // ---------------------------------------------------------------
  // mask word
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      mask_reg <= MASK_DEFAULT;
    end else if (word_pulse && cmd_byte == CMD_WR_MASK) begin
      mask_reg <= rx_word;
    end
  end

  // ---------------------------------------------------------------
  // interrupt pins
  // ---------------------------------------------------------------
  // held low for the whole read, then re-evaluated when the frame ends
  wire irq_next = (|(status_next & ~mask_reg)) & ~(rd_active_reg & ~frame_end) & ~rd_status_cmd
                  & ~soft_rst;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_one_reg <= 1'b0;
      irq_two_reg <= 1'b0;
    end else begin
      irq_one_reg <= irq_next & pin_function_select[SEL_PIN_ONE];
      irq_two_reg <= irq_next & pin_function_select[SEL_PIN_TWO];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= soft_rst;
    end
  end

  assign reset_irq_pin_one = irq_one_reg;
  assign reset_irq_pin_two = irq_two_reg;
  assign event_status      = status_reg;
  assign event_mask        = mask_reg;
  assign soft_reset_pulse  = soft_reset_reg;
endmodule : sia_status_aggregator

// >>> sia_checker_properties.sv
// Purpose : concurrent checks on the status aggregator ports
// Assumes : one clock domain, sclk far slower than clock
// Notes   : helper logic follows status-read frames from the wire
`timescale 1ns/1ns
module sia_checker
  import sia_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        dout_oe,
  input  wire logic        supply_a_low,
  input  wire logic        supply_a_on,
  input  wire logic        supply_b_on,
  input  wire logic [1:0]  pin_function_select,
  input  wire logic        reset_irq_pin_one,
  input  wire logic        reset_irq_pin_two,
  input  wire logic [23:0] event_status,
  input  wire logic [23:0] event_mask,
  input  wire logic        soft_reset_pulse
);
  // ----------
  // frame tracking
  // ----------
  logic [2:0] sclk_q_reg;
  logic [7:0] cmd_reg;
  logic [5:0] rise_cnt_reg;
  logic       rd_act_reg;
  logic [3:0] idle_cnt_reg;
  wire        sclk_rise = sclk_q_reg[1] & ~sclk_q_reg[2];
  wire        idle      = idle_cnt_reg >= 4'h6;
  wire        irq_want  = |(event_status & ~event_mask);
  wire [1:0]  irq_pins  = {reset_irq_pin_two, reset_irq_pin_one};

  always_ff @(posedge clock) begin
    sclk_q_reg <= {sclk_q_reg[1:0], sclk};
    if (!rst_n || cs_n) begin
      rise_cnt_reg <= 6'h00;
      cmd_reg <= 8'h00;
      rd_act_reg <= 1'b0;
    end else if (sclk_rise && rise_cnt_reg < 6'h08) begin
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
      cmd_reg <= {cmd_reg[6:0], din};
    end else if (rise_cnt_reg == 6'h08) begin
      rd_act_reg <= cmd_reg == CMD_RD_STATUS;
    end
    // idle starts well after the read-end merge has landed
    if (!rst_n || !cs_n || dout_oe) idle_cnt_reg <= 4'h0;
    else if (!idle) idle_cnt_reg <= idle_cnt_reg + 4'h1;
  end

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_IRQ_LEVEL: assert property (
    idle && $stable(pin_function_select) && $stable(event_mask)
    |-> irq_pins == (pin_function_select & {2{irq_want}})) else $error("irq pins wrong");
  AST_STICKY: assert property (
    idle && $past(idle) |-> (event_status[15:0] & $past(event_status[15:0]))
    == $past(event_status[15:0])) else $error("edge flag lost");
  AST_RESET_VAL: assert property (
    $rose(rst_n) |-> event_mask == MASK_DEFAULT && event_status == STATUS_POWER_UP)
    else $error("reset values wrong");
  AST_SOFT_RST: assert property (
    soft_reset_pulse |-> event_mask == MASK_DEFAULT && event_status[20:0] == 21'h000000)
    else $error("soft reset left state");
  AST_RD_RELEASE: assert property (
    $rose(rd_act_reg) |-> ##[0:6] irq_pins == 2'h0) else $error("irq kept in read");
  AST_RD_HOLD: assert property (
    rd_act_reg && $past(rd_act_reg, 3) |-> $stable(event_status[15:0]))
    else $error("status moved in read");
  AST_REASSERT: assert property (
    $rose(cs_n) |-> ##[6:12] irq_pins == (pin_function_select & {2{irq_want}}))
    else $error("irq not restored");
  AST_SUPPLY_KEEP: assert property (
    idle && supply_a_low && supply_a_on && $past(supply_a_low, 4) && $past(supply_a_on, 4)
    |-> event_status[BIT_SUPPLY_A]) else $error("supply flag clear while low");
  AST_MON_OFF: assert property (
    !supply_b_on && !$past(supply_b_on) && !$past(event_status[BIT_SUPPLY_B])
    |-> !event_status[BIT_SUPPLY_B]) else $error("flag set by idle monitor");
endmodule : sia_checker

bind sia_status_aggregator sia_checker u_chk (.clock, .rst_n, .sclk, .cs_n, .din,
  .dout_oe, .supply_a_low, .supply_a_on, .supply_b_on, .pin_function_select,
  .reset_irq_pin_one, .reset_irq_pin_two, .event_status, .event_mask, .soft_reset_pulse);

// >>> sia_host_model.sv
// Purpose : host side of the serial port, frames asked for by the bench
// Assumes : mode 0, sclk 64 ns, still and low between frames
// Notes   : idle din shows the inverse of its last bit
`timescale 1ns/1ns
module sia_host_model (
  input  wire logic        clock,
  input  wire logic        dout,
  output logic             sclk,
  output logic             cs_n,
  output logic             din,
  output logic             rd_valid,
  output logic [23:0]      rd_data
);
  initial begin
    sclk     = 1'b0;
    cs_n     = 1'b1;
    din      = 1'b0;
    rd_valid = 1'b0;
    rd_data  = 24'h000000;
  end

  // fewer rises than the command needs makes an aborted frame
  task automatic frame(input logic [7:0] cmd, input logic [23:0] data, input int rises);
    logic [31:0] sh;
    sh = {cmd, data};
    @(posedge clock);
    #1 cs_n = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    for (int i = 0; i < rises; i++) begin
      din = sh[31 - i];
      repeat (4) @(posedge clock);
      #1 sclk = 1'b1;
      // dout moves only after falls, except the word load after the 8th rise
      repeat (4) @(posedge clock);
      if (i >= 8) rd_data[31 - i] = dout;
      #1 sclk = 1'b0;
    end
    repeat (4) @(posedge clock);
    #1 cs_n = 1'b1;
    din = ~din;
    rd_valid = cmd[7] && rises == 32;
    @(posedge clock);
    #1 rd_valid = 1'b0;
    repeat (8) @(posedge clock);
    #1;
  endtask : frame
endmodule : sia_host_model

// >>> sia_testbench.sv
// Purpose : self-checking bench for the status aggregator
// Assumes : host model drives the serial port, bench drives the event sources
// Notes   : read words are queued and compared when the host returns them
`timescale 1ns/1ns
module testbench;
  import sia_pkg::*;
  logic        clock, rst_n, sclk, cs_n, din, dout, dout_oe, rd_valid, sr_seen;
  logic        supply_a_low, supply_b_low, analog_supply_low;
  logic        supply_a_on, supply_b_on, analog_supply_on;
  logic        conv_done_evt, result_read, buffer_write_evt, buffer_access;
  logic        accum_full_evt, accum_access, upper_alarm_evt, lower_alarm_evt;
  logic        upper_threshold_write, lower_threshold_write, soft_reset_pulse;
  logic        reset_irq_pin_one, reset_irq_pin_two;
  logic [1:0]  pin_function_select;
  logic [2:0]  lows, ons;
  logic [3:0]  buffer_write_addr, buffer_full_index;
  logic [3:0]  analog_programmable_pin, digital_programmable_pin;
  logic [9:0]  pv;
  logic [23:0] event_status, event_mask, rd_data, expv, rnd;
  logic [23:0] exp_q[$];
  int          num_errors, n_tests, i;
  wire  [23:0] irqs = {22'h000000, reset_irq_pin_two, reset_irq_pin_one};

  assign {supply_a_low, supply_b_low, analog_supply_low} = lows;
  assign {supply_a_on, supply_b_on, analog_supply_on} = ons;
  // pv[4:0] set bits 20..16, pv[9:5] clear them
  assign {result_read, buffer_access, accum_access, upper_threshold_write,
          lower_threshold_write, conv_done_evt, buffer_write_evt, accum_full_evt,
          upper_alarm_evt, lower_alarm_evt} = pv;

  sia_status_aggregator dut (.clock, .rst_n, .sclk, .cs_n, .din, .dout, .dout_oe,
    .supply_a_low, .supply_b_low, .analog_supply_low, .supply_a_on, .supply_b_on,
    .analog_supply_on, .conv_done_evt, .result_read, .buffer_write_evt,
    .buffer_write_addr, .buffer_full_index, .buffer_access, .accum_full_evt,
    .accum_access, .upper_alarm_evt, .lower_alarm_evt, .upper_threshold_write,
    .lower_threshold_write, .analog_programmable_pin, .digital_programmable_pin,
    .pin_function_select, .reset_irq_pin_one, .reset_irq_pin_two, .event_status,
    .event_mask, .soft_reset_pulse);
  sia_host_model host (.clock, .dout, .sclk, .cs_n, .din, .rd_valid, .rd_data);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----------
  // helpers
  // ----------
  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic pulse(input logic [9:0] v);
    pv = v;
    tick(1);
    pv = 10'h000;
    tick(2);
  endtask : pulse

  task automatic rd(input logic [7:0] cmd, input logic [23:0] want);
    exp_q.push_back(want);
    host.frame(cmd, 24'h000000, 32);
  endtask : rd

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  always @(posedge rd_valid) check(rd_data, exp_q.pop_front());
  always @(posedge clock) if (soft_reset_pulse === 1'b1) sr_seen <= 1'b1;

  // hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end

  // ----------
  // scenarios
  // ----------
  initial begin
    {rst_n, sr_seen, pv, pin_function_select, lows} = '0;
    {analog_programmable_pin, digital_programmable_pin} = 8'h00;
    {buffer_write_addr, buffer_full_index} = 8'h00;
    ons = 3'h7;
    num_errors = 0;
    n_tests = 0;
    rnd = 24'h017723;
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    tick(1);
    check(event_status, STATUS_POWER_UP);
    check(event_mask, MASK_DEFAULT);
    check(irqs, 24'h000000);
    rd(CMD_RD_STATUS, STATUS_POWER_UP);
    rd(CMD_RD_MASK, MASK_DEFAULT);
    check(event_status, STATUS_DEFAULT);
    $display("test power_up done");
    rnd = lfsr(rnd);
    buffer_full_index = rnd[3:0];
    buffer_write_addr = rnd[3:0] + 4'h1;
    pulse(10'h008);
    check(event_status, 24'h000000);
    buffer_write_addr = rnd[3:0];
    expv = 24'h000000;
    for (i = 0; i < 5; i++) begin
      pulse(10'h001 << i);
      expv[16 + i] = 1'b1;
      check(event_status, expv);
    end
    for (i = 0; i < 16; i++) begin
      if (i[2]) digital_programmable_pin[i[1:0]] = ~digital_programmable_pin[i[1:0]];
      else analog_programmable_pin[i[1:0]] = ~analog_programmable_pin[i[1:0]];
      tick(6);
      expv[12 - 8 * i[2] - 4 * i[3] + i[1:0]] = 1'b1;
      check(event_status, expv);
    end
    for (i = 0; i < 3; i++) begin
      lows[i] = 1'b1;
      tick(6);
      lows[i] = 1'b0;
      tick(4);
      expv[21 + i] = 1'b1;
      check(event_status, expv);
    end
    pulse(10'h01F);
    check(event_status, 24'hFFFFFF);
    $display("test set_order done");
    rnd = lfsr(rnd);
    rnd[23] = 1'b0;
    host.frame(CMD_WR_MASK, rnd, 32);
    check(event_mask, rnd);
    rd(CMD_RD_MASK, rnd);
    for (i = 0; i < 4; i++) begin
      pin_function_select = i[1:0];
      tick(3);
      check(irqs, {22'h000000, i[1:0]});
    end
    $display("test mask_pins done");
    host.frame(CMD_WR_MASK, 24'hEFFFFF, 32);
    exp_q.push_back(24'hFFFFFF);
    fork
      host.frame(CMD_RD_STATUS, 24'h000000, 32);
      begin
        tick(150);
        check(irqs, 24'h000000);
        check(dout_oe, 1'b1);
        pulse(10'h010);
        check(event_status, 24'hFFFFFF);
      end
    join
    check(event_status, 24'h100000);
    check(irqs, 24'h000003);
    host.frame(CMD_RD_STATUS, 24'h000000, 20);
    check(event_status, 24'h100000);
    check(irqs, 24'h000003);
    $display("test read_defer done");
    pulse(10'h01F);
    expv = 24'h1F0000;
    for (i = 0; i < 5; i++) begin
      pulse(10'h020 << i);
      expv[16 + i] = 1'b0;
      check(event_status, expv);
    end
    check(irqs, 24'h000000);
    lows = 3'h4;
    tick(6);
    rd(CMD_RD_STATUS, 24'h800000);
    check(event_status, 24'h800000);
    lows = 3'h0;
    tick(4);
    rd(CMD_RD_STATUS, 24'h800000);
    check(event_status, 24'h000000);
    ons = 3'h5;
    lows = 3'h2;
    tick(6);
    check(event_status, 24'h000000);
    lows = 3'h0;
    tick(4);
    ons = 3'h7;
    $display("test clears done");
    host.frame(CMD_WR_MASK, 24'h000000, 32);
    pulse(10'h01F);
    host.frame(CMD_WR_RESET, 24'h000000, 16);
    check(event_status, STATUS_DEFAULT);
    check(event_mask, MASK_DEFAULT);
    check({23'h000000, sr_seen}, 24'h000001);
    $display("test soft_reset done");
    stop_test();
  end
endmodule : testbench
